// >>> core/vpwrx_err_handler.sv
// Purpose: VPW receive filter, symbol decoder, CRC check and bus error handling
// Assumes: bus active is a high level on raw_receive_input; transmitter is outside
// Notes: transmit pin is gated here so faults stop the drive at once
// Operation
// (RULE_01) Flag CRC error when residue not C4
// (RULE_02) CRC error raises interrupt, waits for SOF
// (RULE_03) Invalid symbol in frame sets invalid flag
// (RULE_04) Invalid symbol while sending means lost arbitration
// (RULE_05) EOD off byte boundary is framing error
// (RULE_06) Bus stuck active blocks transmission start
// (RULE_07) Ground short aborts frame until new command
// (RULE_08) Ground short reported as invalid symbol code
// (RULE_09) Fault gone means normal operation, no reset
// (RULE_10) Break raises interrupt; status read clears it
// (RULE_11) After break wait idle, then SOF
// (RULE_12) Never drive a break onto the bus
// (RULE_13) Noise while sending stops drive, raises interrupt
// (RULE_14) Active bus after own EOD is error
// (RULE_15) Sample raw input on link rising edge
// (RULE_16) Count on following falling edge, up/down
// (RULE_17) Count 15 sets output, saturates there
// (RULE_18) Count 0 clears output, saturates there
// (RULE_19) Output holds until opposite end point
// (RULE_20) Clean edge appears after 15-16 periods
// (RULE_21) Mid-length noise decoded as invalid symbol
// (RULE_22) CRC x8+x4+x3+x2+1, preset ones, includes CRC
// (RULE_23) Transmit error stops drive, recorded in status; the drive length cut stops drive but sets no status code
// (RULE_24) Four-bit saturating counter, end-point latch
`timescale 1ns/1ns
module vpwrx_err_handler
	import vpwrx_pkg::*;
#(
	parameter int DIV = LINK_DIV
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic raw_receive_input,
	input wire logic tx_start,
	input wire logic tx_busy,
	input wire logic tx_drive,
	input wire logic tx_eod_sent,
	input wire logic bsv_read,
	output logic tx_pin,
	output logic tx_grant,
	output logic tx_abort,
	output logic lost_arb,
	output logic filt_rx,
	output logic [7:0] rx_byte,
	output logic rx_byte_valid,
	output logic [7:0] bus_state_vector_reg,
	output logic crc_err_irq,
	output logic sym_err_irq
);
	localparam int DIV_W = $clog2(DIV);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
	localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(DIV / 2);
	localparam logic [WID_W-1:0] WID_ONE = WID_W'(1);
	localparam logic [WID_W-1:0] WID_MAX = {WID_W{1'b1}};

	generate
		if (DIV < 4) begin : g_chk
			$error("link divider too small for two clock phases");
		end
	endgenerate

	logic raw_s1_q;
	logic raw_s2_q;
	logic [DIV_W-1:0] div_q;
	logic sample_en;
	logic update_en;
	logic filt_prev_q;
	logic [WID_W-1:0] wid_q;
	vpwrx_state_type st_q;
	logic [7:0] crc_q;
	logic [7:0] shift_q;
	logic [3:0] bitcnt_q;
	logic tx_halt_q;
	logic eod_watch_q;
	logic [WID_W-1:0] drv_cnt_q;
	logic [WID_W-1:0] gnd_cnt_q;

	// Width class of a finished level period
	function automatic vpwrx_sym_type classify(input logic [WID_W-1:0] w);
		if (w < T_SHORT_MIN) begin
			classify = SYM_NOISE;
		end else if (w < T_LONG_MIN) begin
			classify = SYM_SHORT;
		end else if (w < T_SOF_MIN) begin
			classify = SYM_LONG;
		end else if (w < T_BREAK_MIN) begin
			classify = SYM_SOF;
		end else begin
			classify = SYM_OVER;
		end
	endfunction

	// One-cycle strobe as the running width reaches a threshold
	function automatic logic reach(input logic [WID_W-1:0] w, input logic [WID_W-1:0] t,
		input logic tick, input logic edge_now);
		reach = tick && !edge_now && (w == t - WID_ONE);
	endfunction

	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
		crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and link clock phases

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			raw_s1_q <= 1'b0;
			raw_s2_q <= 1'b0;
		end else begin
			raw_s1_q <= raw_receive_input;
			raw_s2_q <= raw_s1_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			div_q <= '0;
		end else if (div_q == DIV_LAST) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + DIV_W'(1);
		end
	end

	assign sample_en = (div_q == '0);
	assign update_en = (div_q == DIV_HALF);

	// Sixteen-state filter gives the 15 to 16 period lag
	vpwrx_rx_filter #(
		.CNT_W(FILT_CNT_W)
	) u_filter (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sample_en(sample_en),
		.update_en(update_en),
		.rx_level(raw_s2_q),
		.filt_out(filt_rx)
	); // RULE_20

	////////////////////////////////////////////////////////////////////////
	// Level width measurement

	logic fedge;
	vpwrx_sym_type cls;
	logic bit_val;

	assign fedge = (filt_rx != filt_prev_q);
	assign cls = classify(wid_q);
	// Active short is 1, passive short is 0
	assign bit_val = (cls == SYM_SHORT) ~^ filt_prev_q;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			filt_prev_q <= 1'b0;
			wid_q <= '0;
		end else begin
			filt_prev_q <= filt_rx;
			if (fedge) begin
				wid_q <= '0;
			end else if (update_en && wid_q != WID_MAX) begin
				wid_q <= wid_q + WID_ONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Symbol events

	logic ev_break;
	logic ev_bit;
	logic ev_eod;
	logic ev_frame_err;
	logic ev_crc_bad;
	logic ev_noise;
	logic ev_sym_err;
	logic ev_eod_clash;
	logic ev_gnd;
	logic ev_overdrive;
	logic in_data;

	assign in_data = (st_q == ST_DATA);
	assign ev_break = filt_rx && reach(wid_q, T_BREAK_MIN, update_en, fedge);
	assign ev_eod = in_data && !filt_rx && reach(wid_q, T_EOD_MIN, update_en, fedge);
	assign ev_frame_err = ev_eod && (bitcnt_q != '0); // RULE_05
	assign ev_crc_bad = ev_eod && (bitcnt_q == '0) && (crc_q != CRC_RESIDUE); // RULE_01
	// Edges shorter than a legal symbol count as noise bits
	assign ev_noise = in_data && fedge && (cls == SYM_NOISE); // RULE_21
	assign ev_sym_err = in_data && fedge && (cls == SYM_SOF || cls == SYM_OVER); // RULE_03
	assign ev_bit = in_data && fedge && (cls == SYM_SHORT || cls == SYM_LONG);
	assign ev_eod_clash = eod_watch_q && fedge && filt_rx; // RULE_14
	assign ev_gnd = tx_pin && !filt_rx && update_en && (gnd_cnt_q == T_GND_FAULT - WID_ONE);
	assign ev_overdrive = tx_pin && update_en && (drv_cnt_q == T_DRIVE_MAX - WID_ONE);

	////////////////////////////////////////////////////////////////////////
	// Receive state machine

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q <= ST_WAIT_IDLE;
		end else if (ev_break) begin
			st_q <= ST_WAIT_IDLE; // RULE_11
		end else begin
			case (st_q)
				ST_WAIT_IDLE: begin
					if (!filt_rx && reach(wid_q, T_IDLE_MIN, update_en, fedge)) begin
						st_q <= ST_WAIT_SOF; // RULE_11
					end
				end
				ST_WAIT_SOF: begin
					if (fedge && !filt_rx && cls == SYM_SOF) begin
						st_q <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (ev_eod || ev_noise || ev_sym_err || ev_eod_clash) begin
						st_q <= ST_WAIT_SOF; // RULE_02
					end
				end
				default: begin
					st_q <= ST_WAIT_IDLE;
				end
			endcase
		end
	end

	// Serial CRC over every bit after SOF, the CRC byte included
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			crc_q <= CRC_PRESET;
			shift_q <= '0;
			bitcnt_q <= '0;
		end else if (st_q != ST_DATA) begin
			crc_q <= CRC_PRESET; // RULE_22
			bitcnt_q <= '0;
		end else if (ev_bit) begin
			crc_q <= crc_step(crc_q, bit_val); // RULE_22
			shift_q <= {shift_q[6:0], bit_val};
			bitcnt_q <= (bitcnt_q == BITS_PER_BYTE - 4'h1) ? 4'h0 : bitcnt_q + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rx_byte <= '0;
			rx_byte_valid <= 1'b0;
		end else begin
			rx_byte_valid <= ev_bit && (bitcnt_q == BITS_PER_BYTE - 4'h1);
			if (ev_bit && bitcnt_q == BITS_PER_BYTE - 4'h1) begin
				rx_byte <= {shift_q[6:0], bit_val};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit supervision

	logic abort_now;
	logic inv_set;
	logic arb_set;

	// Noise or a break while sending stops the drive; a bad symbol is lost arbitration
	assign arb_set = ev_sym_err && tx_busy; // RULE_04
	assign abort_now = ev_gnd || ev_overdrive || ev_eod_clash
		|| (tx_busy && (ev_noise || ev_break || ev_frame_err)); // RULE_13
	assign inv_set = ev_noise || ev_frame_err || ev_break || ev_eod_clash || ev_gnd
		|| (ev_sym_err && !tx_busy);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_halt_q <= 1'b0;
		end else if (abort_now) begin
			tx_halt_q <= 1'b1; // RULE_07
		end else if (tx_start) begin
			tx_halt_q <= 1'b0; // RULE_09
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_pin <= 1'b0;
			tx_abort <= 1'b0;
			lost_arb <= 1'b0;
		end else begin
			tx_pin <= tx_drive && !tx_halt_q && !abort_now && !arb_set; // RULE_23
			tx_abort <= abort_now;
			lost_arb <= arb_set;
		end
	end

	// Drive length limit and ground short watch, in link ticks
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			drv_cnt_q <= '0;
			gnd_cnt_q <= '0;
		end else begin
			if (!tx_pin) begin
				drv_cnt_q <= '0;
			end else if (update_en && drv_cnt_q != WID_MAX) begin
				drv_cnt_q <= drv_cnt_q + WID_ONE; // RULE_12
			end
			if (!tx_pin || filt_rx) begin
				gnd_cnt_q <= '0;
			end else if (update_en && gnd_cnt_q != WID_MAX) begin
				gnd_cnt_q <= gnd_cnt_q + WID_ONE;
			end
		end
	end

	// Only a passive bus past the idle time lets a frame begin
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_grant <= 1'b0;
		end else begin
			tx_grant <= !filt_rx && (wid_q >= T_IDLE_MIN) && !tx_halt_q; // RULE_06
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			eod_watch_q <= 1'b0;
		end else if (tx_eod_sent) begin
			eod_watch_q <= 1'b1;
		end else if (ev_eod_clash || reach(wid_q, T_EOD_MIN, update_en, fedge)) begin
			eod_watch_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus state vector and interrupt conditions

	logic [7:0] code_new;

	always_comb begin
		code_new = BSV_NONE;
		if (inv_set) begin
			code_new = BSV_INVALID; // RULE_08
		end else if (ev_crc_bad) begin
			code_new = BSV_CRC_ERR;
		end else if (arb_set) begin
			code_new = BSV_LOST_ARB;
		end else if (ev_bit && bitcnt_q == BITS_PER_BYTE - 4'h1) begin
			code_new = BSV_RX_DATA;
		end
	end

	// A fresh event in the read cycle survives the clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bus_state_vector_reg <= BSV_NONE;
		end else if (bsv_read) begin
			bus_state_vector_reg <= code_new; // RULE_10
		end else if (code_new > bus_state_vector_reg) begin
			bus_state_vector_reg <= code_new; // RULE_23
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			crc_err_irq <= 1'b0;
			sym_err_irq <= 1'b0;
		end else begin
			crc_err_irq <= ev_crc_bad || (crc_err_irq && !bsv_read); // RULE_02
			sym_err_irq <= inv_set || (sym_err_irq && !bsv_read); // RULE_10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	crc_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_01
		ev_eod && bitcnt_q == '0 && crc_q != CRC_RESIDUE |=>
		crc_err_irq && st_q == ST_WAIT_SOF && bus_state_vector_reg >= BSV_CRC_ERR)
		else $error("bad residue not flagged");
	frame_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
		ev_eod && bitcnt_q != '0 |=> sym_err_irq && st_q == ST_WAIT_SOF && !$rose(crc_err_irq))
		else $error("framing error not flagged");
	lost_arb_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
		ev_sym_err && tx_busy && !inv_set |=> lost_arb && !tx_pin && !$rose(sym_err_irq))
		else $error("symbol error while sending not lost arbitration");
	break_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_11
		ev_break |=> st_q == ST_WAIT_IDLE && sym_err_irq
		&& bus_state_vector_reg == BSV_INVALID)
		else $error("break not handled");
	no_break_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_12
		drv_cnt_q == T_DRIVE_MAX |-> ##[1:2] !tx_pin)
		else $error("drive held toward break length");
	gnd_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_07
		ev_gnd |=> tx_abort && tx_halt_q && !tx_pin ##1 (tx_halt_q || $past(tx_start)))
		else $error("ground short not aborted");
	busy_bus_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_06
		tx_grant |-> $past(!filt_rx) && (!tx_halt_q || tx_abort))
		else $error("grant with bus active");
	read_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_10
		bsv_read && !inv_set |=> !sym_err_irq)
		else $error("status read did not clear invalid symbol");
	noise_tx_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_13
		ev_noise && tx_busy |=> tx_abort && !tx_pin && sym_err_irq)
		else $error("noise while sending not handled");

	good_frame_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		ev_eod && bitcnt_q == '0 && crc_q == CRC_RESIDUE);
	crc_bad_c: cover property (@(posedge ref_clk) disable iff (!rst_n) ev_crc_bad);
	break_c: cover property (@(posedge ref_clk) disable iff (!rst_n) ev_break);
	gnd_c: cover property (@(posedge ref_clk) disable iff (!rst_n) ev_gnd);
endmodule

// >>> core/vpwrx_pkg.sv
// Purpose: shared constants and types of the VPW receive filter and error handler
// Assumes: 125 MHz ref_clk, link interface clock derived by an enable divider
// Notes: symbol windows are in microseconds and converted to link ticks here
package vpwrx_pkg;
	localparam int REF_PERIOD_NS = 8;
	// Link interface clock period, plain default
	localparam int LINK_PERIOD_NS = 1000;
	localparam int LINK_DIV = LINK_PERIOD_NS / REF_PERIOD_NS;
	localparam int FILT_CNT_W = 4;
	localparam int WID_W = 9;

	// Least times round up to whole link ticks
	function automatic logic [WID_W-1:0] vpwrx_tk(input int us);
		vpwrx_tk = WID_W'((us * 1000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
	endfunction

	localparam int SHORT_MIN_US = 34;
	localparam int LONG_MIN_US = 96;
	localparam int SOF_MIN_US = 163;
	localparam int EOD_MIN_US = 163;
	localparam int BREAK_MIN_US = 239;
	localparam int IDLE_MIN_US = 300;
	localparam int GND_FAULT_US = 20;
	localparam logic [WID_W-1:0] T_SHORT_MIN = vpwrx_tk(SHORT_MIN_US);
	localparam logic [WID_W-1:0] T_LONG_MIN = vpwrx_tk(LONG_MIN_US);
	localparam logic [WID_W-1:0] T_SOF_MIN = vpwrx_tk(SOF_MIN_US);
	localparam logic [WID_W-1:0] T_EOD_MIN = vpwrx_tk(EOD_MIN_US);
	localparam logic [WID_W-1:0] T_BREAK_MIN = vpwrx_tk(BREAK_MIN_US);
	localparam logic [WID_W-1:0] T_IDLE_MIN = vpwrx_tk(IDLE_MIN_US);
	localparam logic [WID_W-1:0] T_GND_FAULT = vpwrx_tk(GND_FAULT_US);
	// Own drive is cut before it could ever reach break length
	localparam logic [WID_W-1:0] T_DRIVE_MAX = vpwrx_tk(BREAK_MIN_US) - 9'h002;

	localparam logic [7:0] CRC_POLY = 8'h1D;
	localparam logic [7:0] CRC_PRESET = 8'hFF;
	localparam logic [7:0] CRC_RESIDUE = 8'hC4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Bus state vector codes, larger code has priority
	localparam logic [7:0] BSV_NONE = 8'h00;
	localparam logic [7:0] BSV_RX_DATA = 8'h04;
	localparam logic [7:0] BSV_LOST_ARB = 8'h14;
	localparam logic [7:0] BSV_CRC_ERR = 8'h18;
	localparam logic [7:0] BSV_INVALID = 8'h1C;

	typedef enum logic [1:0] {
		ST_WAIT_IDLE,
		ST_WAIT_SOF,
		ST_DATA
	} vpwrx_state_type;

	typedef enum logic [2:0] {
		SYM_NOISE,
		SYM_SHORT,
		SYM_LONG,
		SYM_SOF,
		SYM_OVER
	} vpwrx_sym_type;
endpackage

// >>> core/vpwrx_rx_filter.sv
// Purpose: saturating up/down noise filter on the synchronised receive level
// Assumes: sample_en and update_en are one-cycle enables half a link period apart
// Notes: output only moves at the counter end points
`timescale 1ns/1ns
module vpwrx_rx_filter
	import vpwrx_pkg::*;
#(
	parameter int CNT_W = FILT_CNT_W
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sample_en,
	input wire logic update_en,
	input wire logic rx_level,
	output logic filt_out
);
	localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
	localparam logic [CNT_W-1:0] CNT_MIN = '0;
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic sample_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	generate
		if (CNT_W < 2) begin : g_chk
			$error("filter counter too narrow");
		end
	endgenerate

	// Rising-edge phase of the link clock
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sample_q <= 1'b0;
		end else if (sample_en) begin
			sample_q <= rx_level; // RULE_15
		end
	end

	always_comb begin
		cnt_d = cnt_q;
		if (sample_q && cnt_q != CNT_MAX) begin
			cnt_d = cnt_q + CNT_ONE; // RULE_16
		end else if (!sample_q && cnt_q != CNT_MIN) begin
			cnt_d = cnt_q - CNT_ONE; // RULE_16
		end
	end

	// Falling-edge phase of the link clock
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cnt_q <= CNT_MIN;
		end else if (update_en) begin
			cnt_q <= cnt_d; // RULE_24
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			filt_out <= 1'b0;
		end else if (update_en) begin
			if (cnt_d == CNT_MAX) begin
				filt_out <= 1'b1; // RULE_17
			end else if (cnt_d == CNT_MIN) begin
				filt_out <= 1'b0; // RULE_18
			end
		end
	end

	sat_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_17
		cnt_q == CNT_MAX |-> filt_out)
		else $error("counter at top but output low");
	sat_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_18
		cnt_q == CNT_MIN |-> !filt_out)
		else $error("counter at bottom but output high");
	latch_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_19
		$changed(filt_out) |-> (cnt_q == CNT_MAX || cnt_q == CNT_MIN))
		else $error("output moved at an intermediate count");
endmodule

// >>> test/vpwrx_bus_model.sv
// Purpose: bus and transceiver as seen from the receive pin
// Assumes: bus active is high; a released bus is pulled passive
// Notes: symbol widths are in link ticks of DIV ref cycles
`timescale 1ns/1ns
module vpwrx_bus_model #(
	parameter int DIV = 4,
	parameter int LOOP_DLY = 2
) (
	input wire logic ref_clk,
	input wire logic tx_pin,
	input wire logic gnd_short,
	input wire logic bat_short,
	output logic raw_receive_input
);
	logic ext_active = 1'b0;
	logic lvl = 1'b0;
	logic [LOOP_DLY-1:0] echo = '0;

	// Transceiver loop delay on our own drive
	always @(posedge ref_clk) echo <= {echo[LOOP_DLY-2:0], tx_pin};
	// Faults override the wired-or of all drivers
	assign raw_receive_input = bat_short | (~gnd_short & (ext_active | echo[LOOP_DLY-1]));

	task automatic hold(input logic a, input int ticks);
		#1 ext_active = a;
		repeat (ticks * DIV) @(posedge ref_clk);
	endtask

	task automatic sof();
		hold(1'b1, 200);
		lvl = 1'b0;
	endtask

	// Level alternates every bit, so the width carries the value
	task automatic bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			hold(lvl, (lvl ^ b[i]) ? 128 : 64);
			lvl = ~lvl;
		end
	endtask
endmodule

// >>> test/vpwrx_err_handler_test.sv
// Purpose: self-checking bench for the VPW receive filter and error handler
// Assumes: link tick shortened to DIV ref cycles
// Notes: received bytes are checked against a queue of expected bytes
`timescale 1ns/1ns
module vpwrx_err_handler_test;
	import vpwrx_pkg::*;
	localparam int DIV = 4;
	logic ref_clk, rst_n, raw_receive_input, tx_start, tx_busy, tx_drive;
	logic tx_eod_sent, bsv_read, gnd_short, bat_short, tx_pin, tx_grant;
	logic tx_abort, lost_arb, filt_rx, rx_byte_valid, crc_err_irq, sym_err_irq;
	logic grant_seen;
	logic [7:0] rx_byte, bus_state_vector_reg, d0, d1;
	logic [7:0] exp_q[$];
	int error_cnt, n_tests, n_abort, n_lost, run_hi, max_hi, seed, n;

	vpwrx_err_handler #(.DIV(DIV)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
		.raw_receive_input(raw_receive_input), .tx_start(tx_start), .tx_busy(tx_busy),
		.tx_drive(tx_drive), .tx_eod_sent(tx_eod_sent), .bsv_read(bsv_read),
		.tx_pin(tx_pin), .tx_grant(tx_grant), .tx_abort(tx_abort), .lost_arb(lost_arb),
		.filt_rx(filt_rx), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid),
		.bus_state_vector_reg(bus_state_vector_reg), .crc_err_irq(crc_err_irq),
		.sym_err_irq(sym_err_irq));

	vpwrx_bus_model #(.DIV(DIV), .LOOP_DLY(2)) bus (.ref_clk(ref_clk), .tx_pin(tx_pin),
		.gnd_short(gnd_short), .bat_short(bat_short), .raw_receive_input(raw_receive_input));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////
	// Reference CRC, kept apart from the design's arithmetic
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic fb;
		crc8 = c;
		for (int i = 7; i >= 0; i--) begin
			fb = crc8[7] ^ b[i];
			crc8 = {crc8[6:0], 1'b0} ^ (fb ? 8'h1D : 8'h00);
		end
	endfunction

	task automatic flags(input logic [7:0] code, input logic s, input logic c);
		check(bus_state_vector_reg, code);
		check(sym_err_irq, s);
		check(crc_err_irq, c);
	endtask

	task automatic read_bsv();
		@(posedge ref_clk);
		#1 bsv_read = 1'b1;
		@(posedge ref_clk);
		#1 bsv_read = 1'b0;
		flags(BSV_NONE, 1'b0, 1'b0);
	endtask

	task automatic restart();
		@(posedge ref_clk);
		#1 tx_busy = 1'b0;
		tx_drive = 1'b0;
		tx_start = 1'b1;
		@(posedge ref_clk);
		#1 tx_start = 1'b0;
	endtask

	task automatic frame(input logic [7:0] a, input logic [7:0] b, input logic bad);
		logic [7:0] c;
		c = ~crc8(crc8(8'hFF, a), b) ^ {7'h00, bad};
		exp_q.push_back(a);
		exp_q.push_back(b);
		exp_q.push_back(c);
		bus.sof();
		bus.bits(a, 8);
		bus.bits(b, 8);
		bus.bits(c, 8);
		bus.hold(1'b0, 200);
	endtask

	task automatic measure(input logic a);
		bus.hold(a, 0);
		n = 0;
		while (filt_rx !== a && n < 40 * DIV) begin
			@(posedge ref_clk);
			n++;
		end
		check(n >= 15 * DIV - 2 && n <= 16 * DIV + 4, 1'b1);
	endtask

	always @(posedge ref_clk) begin
		if (tx_abort === 1'b1) n_abort++;
		if (lost_arb === 1'b1) n_lost++;
		if (tx_grant === 1'b1) grant_seen = 1'b1;
		run_hi = (tx_pin === 1'b1) ? run_hi + 1 : 0;
		if (run_hi > max_hi) max_hi = run_hi;
		if (rx_byte_valid === 1'b1) begin
			if (exp_q.size() == 0) check(8'h01, 8'h00);
			else check(rx_byte, exp_q.pop_front());
		end
	end

	initial begin
		repeat (99000) @(posedge ref_clk);
		error_cnt++;
		$display("[FAIL] %0t timeout", $time);
		stop_test();
	end

	////////////////////////////////////////
	initial begin
		seed = 26153;
		{error_cnt, n_tests, n_abort, n_lost, run_hi, max_hi} = '0;
		{rst_n, tx_start, tx_busy, tx_drive, tx_eod_sent, bsv_read} = '0;
		{gnd_short, bat_short, grant_seen} = '0;
		repeat (2) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		bus.hold(1'b0, 310);
		check(tx_grant, 1'b1);
		measure(1'b1);
		measure(1'b0);
		// Too short to reach the top end point
		bus.hold(1'b1, 12);
		check(filt_rx, 1'b0);
		bus.hold(1'b0, 310);
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		frame(d0, d1, 1'b0);
		flags(BSV_RX_DATA, 1'b0, 1'b0);
		read_bsv();
		frame(d1, d0, 1'b1);
		flags(BSV_CRC_ERR, 1'b0, 1'b1);
		read_bsv();
		// Next SOF is taken at once, no idle needed
		frame(d0, 8'hFF, 1'b0);
		flags(BSV_RX_DATA, 1'b0, 1'b0);
		read_bsv();
		bus.sof();
		bus.bits(8'hA0, 4);
		bus.hold(1'b0, 200);
		flags(BSV_INVALID, 1'b1, 1'b0);
		read_bsv();
		tx_busy = 1'b1;
		bus.sof();
		bus.hold(1'b0, 64);
		bus.hold(1'b1, 24);
		bus.hold(1'b0, 40);
		flags(BSV_INVALID, 1'b1, 1'b0);
		check(8'(n_abort), 8'h01);
		restart();
		read_bsv();
		tx_busy = 1'b1;
		bus.sof();
		bus.hold(1'b0, 64);
		bus.hold(1'b1, 200);
		bus.hold(1'b0, 30);
		check(8'(n_lost), 8'h01);
		flags(BSV_LOST_ARB, 1'b0, 1'b0);
		#1 tx_busy = 1'b0;
		bus.hold(1'b0, 200);
		read_bsv();
		bus.sof();
		exp_q.push_back(d1);
		bus.bits(d1, 8);
		// Passive bit ends the last active bit, so the byte completes
		bus.hold(1'b0, 64);
		bus.hold(1'b1, 300);
		bus.hold(1'b0, 20);
		flags(BSV_INVALID, 1'b1, 1'b0);
		read_bsv();
		// A frame before the bus went idle is ignored
		bus.sof();
		bus.bits(8'h5A, 8);
		bus.hold(1'b0, 200);
		flags(BSV_NONE, 1'b0, 1'b0);
		bus.hold(1'b0, 310);
		frame(d1, d1, 1'b0);
		flags(BSV_RX_DATA, 1'b0, 1'b0);
		read_bsv();
		tx_busy = 1'b1;
		bus.sof();
		exp_q.push_back(d0);
		bus.bits(d0, 8);
		#1 tx_eod_sent = 1'b1;
		@(posedge ref_clk);
		#1 tx_eod_sent = 1'b0;
		bus.hold(1'b0, 100);
		bus.hold(1'b1, 64);
		bus.hold(1'b0, 30);
		flags(BSV_INVALID, 1'b1, 1'b0);
		check(8'(n_abort), 8'h02);
		restart();
		bus.hold(1'b0, 310);
		read_bsv();
		// Endless drive request must be cut short of a break
		tx_busy = 1'b1;
		tx_drive = 1'b1;
		bus.hold(1'b0, 260);
		check(max_hi < 239 * DIV, 1'b1);
		check(8'(n_abort), 8'h03);
		restart();
		bus.hold(1'b0, 310);
		read_bsv();
		check(tx_grant, 1'b1);
		gnd_short = 1'b1;
		tx_busy = 1'b1;
		tx_drive = 1'b1;
		bus.hold(1'b0, 40);
		check(8'(n_abort), 8'h04);
		check(tx_pin, 1'b0);
		check(bus_state_vector_reg, BSV_INVALID);
		#1 {tx_busy, tx_drive, gnd_short} = '0;
		bus.hold(1'b0, 310);
		check(tx_grant, 1'b0);
		restart();
		repeat (2) @(posedge ref_clk);
		check(tx_grant, 1'b1);
		read_bsv();
		// Grant may lag the short by the filter delay
		bat_short = 1'b1;
		bus.hold(1'b0, 20);
		grant_seen = 1'b0;
		bus.hold(1'b0, 380);
		check(grant_seen, 1'b0);
		check(sym_err_irq, 1'b1);
		#1 bat_short = 1'b0;
		// Filter lag on the falling edge adds to the idle wait
		bus.hold(1'b0, 330);
		check(tx_grant, 1'b1);
		stop_test();
	end
endmodule
